// *** wdt_pkg.sv ***
/*
  Shared constants and carrier types of the watchdog, alarm and command block.
  Assumes one 250 MHz clock and a host on a byte-wide asynchronous memory bus.
*/
`default_nettype none

package wdt_pkg;
  localparam logic [3:0] OFS_ALM_MIN = 4'h3;
  localparam logic [3:0] OFS_ALM_HOUR = 4'h5;
  localparam logic [3:0] OFS_ALM_DAY = 4'h7;
  localparam logic [3:0] OFS_CMD = 4'hb;
  localparam logic [3:0] OFS_WDP_A = 4'hc;
  localparam logic [3:0] OFS_WDP_B = 4'hd;

  localparam int ALM_MASK_BIT = 7;
  localparam logic [7:0] ALM_DAY_READ_MASK = 8'h87;
  localparam logic [6:0] TOD_CMP_MASK = 7'h7f;
  localparam int CMD_FLAG_WD_BIT = 1;
  localparam int CMD_FLAG_TOD_BIT = 0;

  localparam logic [5:0] CMD_RST = 6'h33;
  localparam logic [7:0] WDP_RST = 8'h00;
  localparam logic [7:0] ALM_RST = 8'h00;

  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 10000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int PULSE_US = 3000;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [3:0] addr;
    logic [7:0] data;
  } wdt_bus_t;

  typedef struct packed {
    logic transfer_gate;
    logic interrupt_pin_swap;
    logic outb_drive_polarity;
    logic pulse_level_select;
    logic watchdog_irq_mask;
    logic tod_irq_mask;
  } wdt_cmd_t;
endpackage

`default_nettype wire

// *** wdt_sync3.sv ***
/*
  Three-stage input synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous; a bit is taken once stages two and three agree.
*/
`default_nettype none

module wdt_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree_w;

  if (W < 1) begin : g_bad_width
    $error("wdt_sync3: width must be at least one");
  end

  // per bit: a change is taken only when the two later stages match
  assign agree_w = ~(s2_q ^ s3_q);

  always_ff @(posedge ref_clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      q_o <= rst_val_i;
    end else begin
      q_o <= (s3_q & agree_w) | (q_o & ~agree_w);
    end
  end
endmodule

`default_nettype wire

// *** wdt_irq_flag.sv ***
/*
  Alarm flag with optional self-releasing pulse of a least length.
  Assumes set and clear are single-cycle pulses on the same clock.
*/
`default_nettype none

module wdt_irq_flag #(
  parameter int PULSE_CYC = wdt_pkg::PULSE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic pulse_mode_i,
  output logic flag_o
);
  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(PULSE_CYC - 1);
  logic [CW-1:0] cnt_q;
  logic expired_w;

  if (PULSE_CYC < 1) begin : g_bad_pulse
    $error("wdt_irq_flag: pulse length must be at least one");
  end

  assign expired_w = pulse_mode_i & (cnt_q == '0);

  // set beats clear so an alarm in the clearing cycle survives
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      flag_o <= 1'b0;
      cnt_q <= '0;
    end else if (set_i) begin
      flag_o <= 1'b1;
      cnt_q <= LOAD;
    end else if (clr_i || (flag_o && expired_w)) begin
      flag_o <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

`default_nettype wire

// *** wdt_alarm_ctrl.sv ***
/*
  Watchdog countdown, time-of-day alarm compare, command byte and interrupt pins.
  Assumes the clock counters sit outside and hand in minutes, hours, days and a
  one-cycle pulse when seconds roll over; the host bus arrives on raw pins.
*/
`default_nettype none

module wdt_alarm_ctrl #(
  parameter int TICK_CYC = wdt_pkg::TICK_CYC,
  parameter int PULSE_CYC = wdt_pkg::PULSE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [7:0] tod_min_i,
  input wire logic [7:0] tod_hour_i,
  input wire logic [7:0] tod_day_i,
  input wire logic tod_minute_roll_i,
  output logic transfer_gate_o,
  output logic irq_out_a_o,
  output logic irq_out_a_oe_o,
  output logic irq_out_b_o,
  output logic irq_out_b_oe_o
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LOAD = TW'(TICK_CYC - 1);

  if (TICK_CYC < 1) begin : g_bad_tick
    $error("wdt_alarm_ctrl: tick divider must be at least one");
  end

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  wdt_pkg::wdt_bus_t bus_raw_w;
  wdt_pkg::wdt_bus_t bus_rst_w;
  wdt_pkg::wdt_bus_t bus_s;

  assign bus_raw_w = '{ce_n: ce_n_i, we_n: we_n_i, oe_n: oe_n_i, addr: addr_i, data: data_i};
  assign bus_rst_w = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 4'h0, data: 8'h00};

  wdt_sync3 #(
    .W($bits(wdt_pkg::wdt_bus_t))
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(bus_raw_w),
    .rst_val_i(bus_rst_w),
    .q_o(bus_s)
  );

  // bus access framing: the strobe pair is treated as one access window
  logic acc_w;
  logic acc_q;
  logic wr_seen_q;
  logic [3:0] lat_addr_q;
  logic [7:0] lat_data_q;
  logic acc_end_w;
  logic wr_commit_w;

  assign acc_w = ~bus_s.ce_n & (~bus_s.we_n | ~bus_s.oe_n);
  assign acc_end_w = acc_q & ~acc_w;
  assign wr_commit_w = acc_end_w & wr_seen_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc_q <= 1'b0;
      wr_seen_q <= 1'b0;
      lat_addr_q <= 4'h0;
      lat_data_q <= 8'h00;
    end else begin
      acc_q <= acc_w;
      if (acc_w) begin
        lat_addr_q <= bus_s.addr;
      end
      if (acc_w && !bus_s.we_n) begin
        lat_data_q <= bus_s.data;
      end
      wr_seen_q <= acc_w & (wr_seen_q | ~bus_s.we_n);
    end
  end

  logic hit_wdp_w;
  logic hit_alm_w;
  logic hit_any_w;
  logic wd_restart_w;
  logic tod_access_w;

  assign hit_wdp_w = (lat_addr_q == wdt_pkg::OFS_WDP_A) || (lat_addr_q == wdt_pkg::OFS_WDP_B);
  assign hit_alm_w = (lat_addr_q == wdt_pkg::OFS_ALM_MIN) || (lat_addr_q == wdt_pkg::OFS_ALM_HOUR)
                     || (lat_addr_q == wdt_pkg::OFS_ALM_DAY);
  assign hit_any_w = hit_wdp_w || hit_alm_w || (lat_addr_q == wdt_pkg::OFS_CMD);
  // reads and writes of either byte restart alike, so order never matters
  assign wd_restart_w = acc_end_w & hit_wdp_w;
  assign tod_access_w = acc_end_w & hit_alm_w;

  // registers
  wdt_pkg::wdt_cmd_t cmd_q;
  logic [7:0] wdp_a_q;
  logic [7:0] wdp_b_q;
  logic [7:0] alm_min_q;
  logic [7:0] alm_hour_q;
  logic [7:0] alm_day_q;
  logic [7:0] wdp_a_d;
  logic [7:0] wdp_b_d;
  logic [15:0] period_w;
  logic [15:0] period_d;

  assign wdp_a_d = (wr_commit_w && lat_addr_q == wdt_pkg::OFS_WDP_A) ? lat_data_q : wdp_a_q;
  assign wdp_b_d = (wr_commit_w && lat_addr_q == wdt_pkg::OFS_WDP_B) ? lat_data_q : wdp_b_q;
  assign period_w = {wdp_b_q, wdp_a_q};
  assign period_d = {wdp_b_d, wdp_a_d};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmd_q <= wdt_pkg::CMD_RST;
      wdp_a_q <= wdt_pkg::WDP_RST;
      wdp_b_q <= wdt_pkg::WDP_RST;
      alm_min_q <= wdt_pkg::ALM_RST;
      alm_hour_q <= wdt_pkg::ALM_RST;
      alm_day_q <= wdt_pkg::ALM_RST;
    end else begin
      wdp_a_q <= wdp_a_d;
      wdp_b_q <= wdp_b_d;
      if (wr_commit_w) begin
        case (lat_addr_q)
          wdt_pkg::OFS_CMD: cmd_q <= lat_data_q[7:2];
          wdt_pkg::OFS_ALM_MIN: alm_min_q <= lat_data_q;
          wdt_pkg::OFS_ALM_HOUR: alm_hour_q <= lat_data_q;
          wdt_pkg::OFS_ALM_DAY: alm_day_q <= lat_data_q & wdt_pkg::ALM_DAY_READ_MASK;
          default: cmd_q <= cmd_q;
        endcase
      end
    end
  end

  // hundredth tick divider, realigned on restart so a fresh period is whole
  logic [TW-1:0] div_q;
  logic tick_w;

  assign tick_w = (div_q == '0);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || wd_restart_w || tick_w) begin
      div_q <= TICK_LOAD;
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  // countdown; the running value is never on the bus
  logic [15:0] cnt_q;
  logic wd_off_w;
  logic wd_event_w;

  assign wd_off_w = (period_w == 16'h0000);
  // a kick landing on the expiry cycle wins, so a timely host is never flagged
  assign wd_event_w = tick_w & ~wd_restart_w & ~wd_off_w & (cnt_q == 16'h0001);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= 16'h0000;
    end else if (wd_restart_w) begin
      cnt_q <= period_d;
    end else if (wd_off_w) begin
      cnt_q <= 16'h0000;
    end else if (wd_event_w) begin
      cnt_q <= period_w;
    end else if (tick_w) begin
      cnt_q <= (cnt_q == 16'h0000) ? period_w : bcd_dec(cnt_q);
    end
  end

  // time-of-day alarm: the mask pattern sets how many fields must match
  logic m_min_w;
  logic m_hour_w;
  logic m_day_w;
  logic eq_min_w;
  logic eq_hour_w;
  logic eq_day_w;
  logic tod_event_w;

  assign m_min_w = alm_min_q[wdt_pkg::ALM_MASK_BIT];
  assign m_hour_w = alm_hour_q[wdt_pkg::ALM_MASK_BIT];
  assign m_day_w = alm_day_q[wdt_pkg::ALM_MASK_BIT];
  assign eq_min_w = ((tod_min_i[6:0] ^ alm_min_q[6:0]) & wdt_pkg::TOD_CMP_MASK) == 7'h00;
  assign eq_hour_w = ((tod_hour_i[6:0] ^ alm_hour_q[6:0]) & wdt_pkg::TOD_CMP_MASK) == 7'h00;
  assign eq_day_w = tod_day_i[2:0] == alm_day_q[2:0];
  // mixed patterns outside the four supported ones are left to fall out as they may
  assign tod_event_w = tod_minute_roll_i & ((m_min_w & m_hour_w & m_day_w)
                       | (eq_min_w & (m_hour_w | eq_hour_w) & (m_day_w | eq_day_w)));

  logic wd_flag_w;
  logic tod_flag_w;

  wdt_irq_flag #(
    .PULSE_CYC(PULSE_CYC)
  ) u_wd_flag (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .set_i(wd_event_w),
    .clr_i(wd_restart_w),
    .pulse_mode_i(cmd_q.pulse_level_select),
    .flag_o(wd_flag_w)
  );

  wdt_irq_flag #(
    .PULSE_CYC(PULSE_CYC)
  ) u_tod_flag (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .set_i(tod_event_w),
    .clr_i(tod_access_w),
    .pulse_mode_i(cmd_q.pulse_level_select),
    .flag_o(tod_flag_w)
  );

  // masking, routing and pin drive
  logic wd_irq_w;
  logic tod_irq_w;
  logic a_act_w;
  logic b_act_w;
  logic a_act_q;
  logic b_act_q;

  assign wd_irq_w = wd_flag_w & ~cmd_q.watchdog_irq_mask;
  assign tod_irq_w = tod_flag_w & ~cmd_q.tod_irq_mask;
  assign a_act_w = cmd_q.interrupt_pin_swap ? tod_irq_w : wd_irq_w;
  assign b_act_w = cmd_q.interrupt_pin_swap ? wd_irq_w : tod_irq_w;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      a_act_q <= 1'b0;
      b_act_q <= 1'b0;
    end else begin
      a_act_q <= a_act_w;
      b_act_q <= b_act_w;
    end
  end

  // a sinks only; b sources when polarity is high, else sinks like a
  assign irq_out_a_o = 1'b0;
  assign irq_out_a_oe_o = a_act_q;
  assign irq_out_b_o = cmd_q.outb_drive_polarity & b_act_q;
  assign irq_out_b_oe_o = cmd_q.outb_drive_polarity | b_act_q;
  assign transfer_gate_o = cmd_q.transfer_gate;

  // read path: live address so flags show while the read strobe is held
  logic [7:0] rd_mux_w;
  logic hit_rd_w;
  logic [7:0] cmd_rd_w;

  assign cmd_rd_w = {cmd_q, wd_flag_w, tod_flag_w};
  assign hit_rd_w = (bus_s.addr == wdt_pkg::OFS_WDP_A) || (bus_s.addr == wdt_pkg::OFS_WDP_B)
                    || (bus_s.addr == wdt_pkg::OFS_ALM_MIN) || (bus_s.addr == wdt_pkg::OFS_CMD)
                    || (bus_s.addr == wdt_pkg::OFS_ALM_HOUR)
                    || (bus_s.addr == wdt_pkg::OFS_ALM_DAY);
  assign rd_mux_w = (bus_s.addr == wdt_pkg::OFS_WDP_A) ? wdp_a_q :
                    (bus_s.addr == wdt_pkg::OFS_WDP_B) ? wdp_b_q :
                    (bus_s.addr == wdt_pkg::OFS_CMD) ? cmd_rd_w :
                    (bus_s.addr == wdt_pkg::OFS_ALM_MIN) ? alm_min_q :
                    (bus_s.addr == wdt_pkg::OFS_ALM_HOUR) ? alm_hour_q :
                    (bus_s.addr == wdt_pkg::OFS_ALM_DAY) ? alm_day_q : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      data_o <= rd_mux_w;
      data_oe_o <= acc_w & bus_s.we_n & ~bus_s.oe_n & hit_rd_w;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_wdp_access;
    acc_end_w && hit_wdp_w;
  endsequence

  sequence s_wd_expiry;
    tick_w && !wd_restart_w && !wd_off_w && cnt_q == 16'h0001;
  endsequence

  chk_wdp_restart_clear: assert property (s_wdp_access
      |=> !wd_flag_w && cnt_q == $past(period_d))
    else $error("period access did not restart and clear");
  chk_wd_expiry_flag: assert property (s_wd_expiry
      |=> wd_flag_w && cnt_q == $past(period_w))
    else $error("expiry did not raise flag and reload");
  chk_wd_zero_off: assert property (wd_off_w && !wd_restart_w |=> !$rose(wd_flag_w))
    else $error("watchdog fired with zero period");
  chk_bcd_low_digit: assert property (tick_w && !wd_restart_w && !wd_off_w
      && cnt_q > 16'h0001
      |=> cnt_q[3:0] == (($past(cnt_q[3:0]) == 4'h0) ? 4'h9 : $past(cnt_q[3:0]) - 4'h1))
    else $error("bcd countdown step wrong");
  chk_pin_routing: assert property (a_act_q == $past(cmd_q.interrupt_pin_swap ? tod_irq_w : wd_irq_w)
      && b_act_q == $past(cmd_q.interrupt_pin_swap ? wd_irq_w : tod_irq_w))
    else $error("alarm routed to wrong pin");
  chk_outb_polarity: assert property (b_act_q
      |-> irq_out_b_oe_o && irq_out_b_o == cmd_q.outb_drive_polarity)
    else $error("output b drive polarity wrong");
  chk_wd_masked: assert property (cmd_q.watchdog_irq_mask |-> !wd_irq_w)
    else $error("masked watchdog reached a pin");
  chk_tod_masked: assert property (cmd_q.tod_irq_mask |-> !tod_irq_w)
    else $error("masked alarm reached a pin");
  chk_tod_access_clear: assert property (tod_access_w && !tod_event_w |=> !tod_flag_w)
    else $error("alarm access did not clear flag");
  chk_tod_all_match: assert property (tod_minute_roll_i && !m_min_w
      && !m_hour_w && !m_day_w && eq_min_w && eq_hour_w && eq_day_w |=> tod_flag_w)
    else $error("full match gave no alarm");
  chk_cmd_write: assert property (wr_commit_w && lat_addr_q == wdt_pkg::OFS_CMD
      |=> transfer_gate_o == $past(lat_data_q[7]))
    else $error("command write not taken");
  chk_flag_readback: assert property (acc_w && bus_s.addr == wdt_pkg::OFS_CMD
      |=> data_o[wdt_pkg::CMD_FLAG_WD_BIT] == $past(wd_flag_w))
    else $error("watchdog flag not shown in command byte");
endmodule

`default_nettype wire

// *** wdt_host_model.sv ***
/*
  Host processor model: drives the byte-wide asynchronous bus pins.
  Assumes the bench calls wr and rd one at a time and waits for each to return.
*/
`default_nettype none

module wdt_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  output var wdt_pkg::wdt_bus_t bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial bus_o = {3'b111, 4'h0, 8'h00};

  // released data lines show the inverse so a stale byte cannot pass
  // idle gap outlasts the pin synchroniser before the next access
  task automatic idle(input logic [3:0] a);
    #1;
    bus_o = {3'b111, a, ~bus_o.data};
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    bus_o = {3'b001, a, d};
    repeat (8) @(posedge ref_clk_i);
    idle(a);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic seen);
    seen = 1'b0;
    d = 'x;
    @(posedge ref_clk_i);
    #1;
    bus_o = {3'b010, a, bus_o.data};
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge ref_clk_i);
      #1;
      seen = (rdata_oe_i === 1'b1);
    end
    if (seen) begin
      d = rdata_i;
    end
    idle(a);
  endtask
endmodule

`default_nettype wire

// *** wdt_alarm_ctrl_tb.sv ***
/*
  Self-checking bench for the watchdog, alarm and command block.
  Assumes short tick and pulse parameters; the host model drives the bus pins.
*/
`default_nettype none

module wdt_alarm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK = 10;
  localparam int PULSE = 20;

  logic ref_clk_i, srst_i, roll, rdata_oe, gate, a_o, a_oe, b_o, b_oe;
  logic [7:0] tmin, thour, tday, rdata;
  logic [3:0] pins;
  wdt_pkg::wdt_bus_t bus;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  assign pins = {a_oe, a_o, b_oe, b_o};

  wdt_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rdata_oe_i(rdata_oe),
    .bus_o(bus));

  wdt_alarm_ctrl #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) DUT (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_n_i(bus.ce_n), .we_n_i(bus.we_n),
    .oe_n_i(bus.oe_n), .addr_i(bus.addr), .data_i(bus.data), .data_o(rdata),
    .data_oe_o(rdata_oe), .tod_min_i(tmin), .tod_hour_i(thour), .tod_day_i(tday),
    .tod_minute_roll_i(roll), .transfer_gate_o(gate), .irq_out_a_o(a_o),
    .irq_out_a_oe_o(a_oe), .irq_out_b_o(b_o), .irq_out_b_oe_o(b_oe)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic close_out();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic seen;
    host.rd(a, d, seen);
    chk(d, exp, "register read");
  endtask

  // pin pattern for swap, polarity and masks held in a command byte
  function automatic logic [3:0] exp_pins(input logic [7:0] cmd, input logic wd,
    input logic tod);
    logic a, b, w, t;
    w = wd & ~cmd[3];
    t = tod & ~cmd[2];
    a = cmd[6] ? t : w;
    b = cmd[6] ? w : t;
    return {a, 1'b0, cmd[5] | b, cmd[5] & b};
  endfunction

  // f names the field set off by one: 0 none, 1 minutes, 2 hours, 3 day
  function automatic logic exp_tod(input logic [2:0] m, input int f);
    return f == 0 || (f == 1 && m[2]) || (f == 2 && m[1]) || (f == 3 && m[0]);
  endfunction

  task automatic wait_pins(input logic [3:0] e, output int n);
    n = 0;
    while (pins !== e && n < 2000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic quiet(input logic [7:0] cmd, input int span);
    int bad;
    bad = 0;
    repeat (span) begin
      @(posedge ref_clk_i);
      if (pins !== exp_pins(cmd, 1'b0, 1'b0)) bad++;
    end
    chk(8'(bad > 0), 8'h00, "pins stayed idle");
  endtask

  task automatic roll_pulse(input logic [7:0] mi, input logic [7:0] hr, input logic [7:0] dy);
    @(posedge ref_clk_i);
    #1;
    {tmin, thour, tday, roll} = {mi, hr, dy, 1'b1};
    @(posedge ref_clk_i);
    #1;
    roll = 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  initial begin
    #(40000 * 4);
    miscompares++;
    $display("BAD %0t watchdog timer ran out", $time);
    close_out();
  end

  initial begin
    logic [7:0] cmd, hund, am, ah, ad, d;
    logic [2:0] mk [4];
    logic seen;
    int n, p, t1;
    void'($urandom(62549));
    mk = '{3'b111, 3'b011, 3'b001, 3'b000};
    {srst_i, roll, tmin, thour, tday} = {2'b10, 24'h000000};
    repeat (20) @(posedge ref_clk_i);
    #1;
    srst_i = 1'b0;
    chk({4'h0, pins}, {4'h0, exp_pins(8'hcc, 1'b0, 1'b0)}, "pins after reset");
    rdc(wdt_pkg::OFS_CMD, 8'hcc);
    rdc(wdt_pkg::OFS_WDP_A, 8'h00);
    host.rd(4'he, d, seen);
    chk({7'h0, seen}, 8'h00, "unmapped offset driven");
    host.wr(wdt_pkg::OFS_CMD, 8'h4f);
    chk({7'h0, gate}, 8'h00, "transfer not frozen");
    rdc(wdt_pkg::OFS_CMD, 8'h4c);
    host.wr(wdt_pkg::OFS_CMD, 8'hcc);
    chk({7'h0, gate}, 8'h01, "transfer not resumed");
    for (int k = 0; k < 4; k++) begin
      cmd = {1'b1, k[1], k[0], 5'h00};
      hund = {4'($urandom_range(1, 9)), 4'($urandom_range(0, 9))};
      p = hund[7:4] * 10 + hund[3:0];
      host.wr(wdt_pkg::OFS_CMD, cmd);
      if (k[0]) begin
        host.wr(wdt_pkg::OFS_WDP_B, 8'h00);
        host.wr(wdt_pkg::OFS_WDP_A, hund);
      end else begin
        host.wr(wdt_pkg::OFS_WDP_A, hund);
        host.wr(wdt_pkg::OFS_WDP_B, 8'h00);
      end
      chk({4'h0, pins}, {4'h0, exp_pins(cmd, 1'b0, 1'b0)}, "pins after restart");
      wait_pins(exp_pins(cmd, 1'b1, 1'b0), n);
      chk(8'(n > p * TICK - 8 && n < p * TICK + 8), 8'h01, "expiry time");
      rdc(wdt_pkg::OFS_WDP_A, hund);
    end
    host.wr(wdt_pkg::OFS_WDP_B, 8'h01);
    host.wr(wdt_pkg::OFS_WDP_A, 8'h00);
    wait_pins(exp_pins(cmd, 1'b1, 1'b0), n);
    chk(8'(n > 100 * TICK - 8 && n < 100 * TICK + 8), 8'h01, "bcd borrow period");
    rdc(wdt_pkg::OFS_CMD, cmd | 8'h02);
    rdc(wdt_pkg::OFS_WDP_B, 8'h01);
    chk({4'h0, pins}, {4'h0, exp_pins(cmd, 1'b0, 1'b0)}, "pins after access");
    rdc(wdt_pkg::OFS_CMD, cmd);
    // pulse mode: width and recurrence with no period access, only a command byte read between
    cmd = 8'hf0;
    host.wr(wdt_pkg::OFS_CMD, cmd);
    host.wr(wdt_pkg::OFS_WDP_B, 8'h00);
    host.wr(wdt_pkg::OFS_WDP_A, 8'h05);
    wait_pins(exp_pins(cmd, 1'b1, 1'b0), n);
    t1 = cyc;
    wait_pins(exp_pins(cmd, 1'b0, 1'b0), n);
    chk(8'(n), 8'(PULSE), "pulse width");
    rdc(wdt_pkg::OFS_CMD, cmd);
    wait_pins(exp_pins(cmd, 1'b1, 1'b0), n);
    chk(8'(cyc - t1), 8'(5 * TICK), "recurrence interval");
    cmd = 8'hf8;
    host.wr(wdt_pkg::OFS_CMD, cmd);
    host.wr(wdt_pkg::OFS_WDP_A, 8'h05);
    quiet(cmd, 150);
    cmd = 8'he0;
    host.wr(wdt_pkg::OFS_CMD, cmd);
    host.wr(wdt_pkg::OFS_WDP_A, 8'h00);
    quiet(cmd, 300);
    rdc(wdt_pkg::OFS_CMD, cmd);
    cmd = 8'hc8;
    host.wr(wdt_pkg::OFS_CMD, cmd);
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 4; f++) begin
        am = {4'($urandom_range(0, 5)), 4'($urandom_range(0, 9))};
        ah = {4'($urandom_range(0, 1)), 4'($urandom_range(0, 9))};
        ad = 8'($urandom_range(1, 7));
        host.wr(wdt_pkg::OFS_ALM_MIN, {mk[m][2], am[6:0]});
        host.wr(wdt_pkg::OFS_ALM_HOUR, {mk[m][1], ah[6:0]});
        host.wr(wdt_pkg::OFS_ALM_DAY, {mk[m][0], 4'h0, ad[2:0]});
        roll_pulse(am ^ 8'(f == 1), ah ^ 8'(f == 2), ad ^ 8'(f == 3));
        chk({7'h0, a_oe}, {7'h0, exp_tod(mk[m], f)}, "alarm pin");
        rdc(wdt_pkg::OFS_CMD, {cmd[7:1], exp_tod(mk[m], f)});
        rdc(wdt_pkg::OFS_ALM_DAY, {mk[m][0], 4'h0, ad[2:0]});
        chk({7'h0, a_oe}, 8'h00, "alarm pin after access");
      end
    end
    host.wr(wdt_pkg::OFS_CMD, 8'hcc);
    host.wr(wdt_pkg::OFS_ALM_DAY, 8'h80);
    roll_pulse(tmin, thour, tday);
    chk({4'h0, pins}, {4'h0, exp_pins(8'hcc, 1'b0, 1'b0)}, "masked alarm pin");
    close_out();
  end
endmodule

`default_nettype wire
